// >>> src/flash_device.sv
// Behaviour
// RULE1: 03h takes 3/4 address bytes, 13h four
// RULE2: Only address bits up to valid MSB decoded
// RULE3: 4-byte: large decodes A24-A0, small A23-A0
// RULE4: Normal read data MSB first, address increments
// RULE5: Address counter wraps to zero past top
// RULE6: Chip select high ends read, output released
// RULE7: Normal read ignored while write in progress
// RULE8: 0Bh takes 3/4 address bytes, 0Ch four
// RULE9: Fast read: opcode, address, dummies on rising edges
// RULE10: Fast read data on falling edges, wrapping
// RULE11: Fast read ignored while write in progress
// RULE12: Quad mode: 2 opcode, 6/8 address, 6 dummy
// RULE13: Quad-mode fast read ignored during write
// RULE14: Quad mode: EBh, 4Bh, 68h; latter two 3-byte
// RULE15: Unique ID: A23-A9 ignored, A8-A4 zero
// RULE16: Mode byte counts within dummy cycles
// RULE17: Pause/resume by pause pin while clock low
// RULE18: Paused: output released, input and clock ignored
// RULE19: No pause in DTR, quad enable, reset pin
// RULE20: Serial input ignored after normal read address
// RULE21: Normal read: first bit on next falling edge
//
// The address-and-strobe memory read port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module flash_device
	import flash_pkg::*;
#(
	parameter bit BIG_DEVICE = 1'b1
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link
	flash_link_if.device lnk,
	// Device status and configuration
	input wire logic write_in_progress,
	input wire logic four_byte_addr_flag,
	input wire logic quad_command_mode,
	input wire logic quad_enable,
	input wire logic dtr_mode,
	input wire logic reset_pin_sel,
	input wire logic [3:0] fast_dummy_cfg,
	input wire logic [3:0] qpi_dummy_cfg,
	// Memory read port, data one cycle after strobe
	output logic mem_rd,
	output logic [24:0] mem_addr,
	output logic [1:0] mem_space,
	input wire logic [7:0] mem_rdata,
	// Status
	output logic read_active,
	output logic cmd_ignored
);
	logic [6:0] p_lvl, p_rise, p_fall;
	logic sel, sck_lvl, rise_ev, fall_ev, hold_ok, paused_r;
	logic [3:0] io_lvl;
	dev_state_e st_r;
	logic [5:0] cnt_r, addr_clks_r;
	logic [7:0] op_r, op_nxt;
	logic [31:0] addr_sr_r, addr_sr_nxt;
	logic [3:0] dummy_r;
	logic [24:0] mask_r, addr_r;
	logic [1:0] space_r;
	logic dec_ok, dec_a4, last_op, last_addr, start_data, next_byte;
	logic [3:0] dec_dummy;
	logic [1:0] dec_space;
	logic fetch_r, fetch_d_r, drive_r, ign_r;
	logic [7:0] byte_r, sh_r;
	logic [2:0] nib_r;
	logic [3:0] out_r;

	// Pin filter: cs_n, hold_n, sck, io
	pin_sync #(.W(7), .RST_VAL(7'h6F)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.din({lnk.cs_n, lnk.hold_n, lnk.sck, lnk.io}),
		.lvl(p_lvl),
		.rise(p_rise),
		.fall(p_fall)
	);
	assign sel = ~p_lvl[6];
	assign sck_lvl = p_lvl[4];
	assign io_lvl = p_lvl[3:0];
	assign hold_ok = ~dtr_mode & ~quad_enable & ~reset_pin_sel; // RULE19

	// Pause tracking
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			paused_r <= 1'b0;
		else if (!sel || !hold_ok) // RULE19
			paused_r <= 1'b0;
		else if (p_fall[5] && !sck_lvl) // RULE17
			paused_r <= 1'b1;
		else if (p_rise[5] && !sck_lvl) // RULE17
			paused_r <= 1'b0;

	// Clock edges count only while selected and not paused
	assign rise_ev = sel & ~paused_r & p_rise[4]; // RULE18
	assign fall_ev = sel & ~paused_r & p_fall[4]; // RULE18

	// Opcode and address shift
	always_comb
	begin
		op_nxt = quad_command_mode ? {op_r[3:0], io_lvl} :
			{op_r[6:0], io_lvl[0]};
		addr_sr_nxt = quad_command_mode ? {addr_sr_r[27:0], io_lvl} :
			{addr_sr_r[30:0], io_lvl[0]};
	end

	// Opcode decode
	always_comb
	begin
		dec_ok = 1'b1;
		dec_a4 = four_byte_addr_flag;
		dec_dummy = (fast_dummy_cfg == 4'h0) ? FAST_DUMMY_RST :
			fast_dummy_cfg; // RULE9
		dec_space = SPACE_ARRAY;
		if (!quad_command_mode)
			case (op_nxt)
				OP_NORMAL_READ: dec_dummy = 4'h0; // RULE1 RULE21
				OP_NORMAL_READ_4B:
				begin
					dec_a4 = 1'b1; // RULE1
					dec_dummy = 4'h0;
				end
				OP_FAST_READ: dec_a4 = four_byte_addr_flag; // RULE8
				OP_FAST_READ_4B: dec_a4 = 1'b1; // RULE8
				default: dec_ok = 1'b0;
			endcase
		else
		begin
			dec_dummy = (qpi_dummy_cfg == 4'h0) ? QPI_DUMMY_RST :
				qpi_dummy_cfg; // RULE12 RULE16
			case (op_nxt) // RULE14
				OP_FAST_READ, OP_QUAD_IO_FAST_READ:
					dec_a4 = four_byte_addr_flag;
				OP_FAST_READ_4B: dec_a4 = 1'b1;
				OP_UNIQUE_ID_READ:
				begin
					dec_a4 = 1'b0;
					dec_space = SPACE_UID;
				end
				OP_INFO_ROW_READ:
				begin
					dec_a4 = 1'b0;
					dec_space = SPACE_INFO;
				end
				default: dec_ok = 1'b0;
			endcase
		end
	end

	assign last_op = rise_ev && st_r == D_CMD &&
		cnt_r == (quad_command_mode ? QPI_OP_CLKS : SPI_OP_CLKS) - 6'h01;
	assign last_addr = rise_ev && st_r == D_ADDR &&
		cnt_r == addr_clks_r - 6'h01;
	assign start_data = (last_addr && dummy_r == 4'h0) ||
		(rise_ev && st_r == D_DUMMY &&
		cnt_r == {2'b00, dummy_r} - 6'h01);
	assign next_byte = fall_ev && st_r == D_DATA && nib_r == 3'h0;

	// Command sequencer
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			st_r <= D_CMD;
			cnt_r <= 6'h00;
			op_r <= 8'h00;
			addr_sr_r <= 32'h00000000;
			addr_clks_r <= SPI_ADDR3_CLKS;
			dummy_r <= 4'h0;
			mask_r <= MASK_VMSB23;
			space_r <= SPACE_ARRAY;
			addr_r <= 25'h0000000;
		end
		else if (!sel) // RULE6
		begin
			st_r <= D_CMD;
			cnt_r <= 6'h00;
			op_r <= 8'h00;
			addr_sr_r <= 32'h00000000;
		end
		else if (last_op)
		begin
			op_r <= op_nxt;
			cnt_r <= 6'h00;
			st_r <= (dec_ok && !write_in_progress) ? D_ADDR :
				D_IGNORE; // RULE7 RULE11 RULE13
			dummy_r <= dec_dummy;
			space_r <= dec_space;
			if (quad_command_mode)
				addr_clks_r <= dec_a4 ? QPI_ADDR4_CLKS : QPI_ADDR3_CLKS;
			else
				addr_clks_r <= dec_a4 ? SPI_ADDR4_CLKS : SPI_ADDR3_CLKS;
			if (dec_space == SPACE_UID)
				mask_r <= MASK_UID; // RULE15
			else if (dec_a4 && BIG_DEVICE)
				mask_r <= MASK_VMSB24; // RULE3
			else
				mask_r <= MASK_VMSB23; // RULE3
		end
		else if (rise_ev && st_r == D_CMD)
		begin
			op_r <= op_nxt;
			cnt_r <= cnt_r + 6'h01;
		end
		else if (rise_ev && st_r == D_ADDR)
		begin
			addr_sr_r <= addr_sr_nxt;
			cnt_r <= cnt_r + 6'h01;
			if (last_addr)
			begin
				addr_r <= addr_sr_nxt[24:0] & mask_r; // RULE2 RULE3
				cnt_r <= 6'h00;
				st_r <= start_data ? D_DATA : D_DUMMY;
			end
		end
		else if (rise_ev && st_r == D_DUMMY) // RULE16
		begin
			cnt_r <= cnt_r + 6'h01;
			if (start_data)
				st_r <= D_DATA;
		end
		else if (next_byte)
			addr_r <= (addr_r + 25'h0000001) & mask_r; // RULE4 RULE5

	// Byte fetch from memory
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			fetch_r <= 1'b0;
			fetch_d_r <= 1'b0;
			byte_r <= 8'h00;
		end
		else
		begin
			fetch_r <= start_data | next_byte;
			fetch_d_r <= fetch_r;
			if (fetch_d_r)
				byte_r <= mem_rdata;
		end

	// Output shifter on falling edges; input ignored here
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			sh_r <= 8'h00;
			nib_r <= 3'h0;
			out_r <= 4'h0;
			drive_r <= 1'b0;
		end
		else if (!sel || st_r != D_DATA) // RULE6 RULE20
		begin
			nib_r <= 3'h0;
			drive_r <= 1'b0;
		end
		else if (next_byte) // RULE4 RULE10 RULE21
		begin
			drive_r <= 1'b1;
			if (quad_command_mode)
			begin
				out_r <= byte_r[7:4]; // RULE12
				sh_r <= {byte_r[3:0], 4'h0};
				nib_r <= 3'h1;
			end
			else
			begin
				out_r <= {2'b00, byte_r[7], 1'b0};
				sh_r <= {byte_r[6:0], 1'b0};
				nib_r <= 3'h7;
			end
		end
		else if (fall_ev)
		begin
			nib_r <= nib_r - 3'h1;
			if (quad_command_mode)
			begin
				out_r <= sh_r[7:4];
				sh_r <= {sh_r[3:0], 4'h0};
			end
			else
			begin
				out_r <= {2'b00, sh_r[7], 1'b0};
				sh_r <= {sh_r[6:0], 1'b0};
			end
		end

	// Ignored-command pulse
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			ign_r <= 1'b0;
		else
			ign_r <= last_op & (~dec_ok | write_in_progress);

	// Pin drive: released when deselected or paused
	assign lnk.dev_o = out_r;
	assign lnk.dev_oe_n = (!sel || !drive_r || paused_r) ? 4'hF : // RULE18
		(quad_command_mode ? 4'h0 : 4'hD);
	assign mem_rd = fetch_r;
	assign mem_addr = addr_r;
	assign mem_space = space_r;
	assign read_active = (st_r == D_DATA);
	assign cmd_ignored = ign_r;
endmodule : flash_device
`default_nettype wire

// >>> src/flash_pkg.sv
package flash_pkg;
	// Read opcodes
	localparam logic [7:0] OP_NORMAL_READ = 8'h03;
	localparam logic [7:0] OP_NORMAL_READ_4B = 8'h13;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_FAST_READ_4B = 8'h0C;
	localparam logic [7:0] OP_QUAD_IO_FAST_READ = 8'hEB;
	localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4B;
	localparam logic [7:0] OP_INFO_ROW_READ = 8'h68;
	// Serial clocks per phase
	localparam logic [5:0] SPI_OP_CLKS = 6'h08;
	localparam logic [5:0] QPI_OP_CLKS = 6'h02;
	localparam logic [5:0] SPI_ADDR3_CLKS = 6'h18;
	localparam logic [5:0] SPI_ADDR4_CLKS = 6'h20;
	localparam logic [5:0] QPI_ADDR3_CLKS = 6'h06;
	localparam logic [5:0] QPI_ADDR4_CLKS = 6'h08;
	// Dummy clock defaults, used when the setting is zero
	localparam logic [3:0] FAST_DUMMY_RST = 4'h8;
	localparam logic [3:0] QPI_DUMMY_RST = 4'h6;
	// Decoded address masks
	localparam logic [24:0] MASK_VMSB24 = 25'h1FFFFFF;
	localparam logic [24:0] MASK_VMSB23 = 25'h0FFFFFF;
	localparam logic [24:0] MASK_UID = 25'h00001FF;
	localparam logic [31:0] UID_ZERO_BITS = 32'h000001F0;
	// Link timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int SCK_PERIOD_NS = 500;
	localparam int DESEL_NS = 250;
	localparam logic [4:0] SCK_HALF_CYC =
		5'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
	localparam logic [4:0] DESEL_CYC =
		5'((DESEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Memory space selector
	typedef enum logic [1:0] {
		SPACE_ARRAY = 2'b00,
		SPACE_UID = 2'b01,
		SPACE_INFO = 2'b10
	} space_e;
	typedef enum logic [2:0] {
		D_CMD = 3'b000,
		D_ADDR = 3'b001,
		D_DUMMY = 3'b010,
		D_DATA = 3'b011,
		D_IGNORE = 3'b100
	} dev_state_e;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_SETUP = 3'b001,
		H_RUN = 3'b010,
		H_END = 3'b011,
		H_GAP = 3'b100
	} host_state_e;
endpackage : flash_pkg

// >>> src/flash_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
	logic sck;
	logic cs_n;
	logic hold_n;
	logic [3:0] dev_o;
	logic [3:0] dev_oe_n;
	logic [3:0] host_o;
	logic [3:0] host_oe_n;
	logic [3:0] io;
	// Wire level: driven value, pulled high when nobody drives
	assign io = (~dev_oe_n & dev_o) | (~host_oe_n & host_o) |
		(dev_oe_n & host_oe_n);
	modport device (input sck, cs_n, hold_n, io, output dev_o, dev_oe_n);
	modport host (output sck, cs_n, hold_n, host_o, host_oe_n, input io);
endinterface : flash_link_if
`default_nettype wire

// >>> src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import flash_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Raw pins and filtered view
	input wire logic [W-1:0] din,
	output logic [W-1:0] lvl,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] s1_r, s2_r, s3_r, lvl_r;

	// Three-stage chain
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end

	// Change counts once stages two and three agree
	for (genvar i = 0; i < W; i++)
	begin : g_bit
		always_ff @(posedge clk or negedge rstn)
			if (!rstn)
				lvl_r[i] <= RST_VAL[i];
			else if (s2_r[i] == s3_r[i])
				lvl_r[i] <= s3_r[i];
		assign rise[i] = s2_r[i] & s3_r[i] & ~lvl_r[i];
		assign fall[i] = ~s2_r[i] & ~s3_r[i] & lvl_r[i];
	end
	assign lvl = lvl_r;
endmodule : pin_sync
`default_nettype wire

// >>> src/flash_host.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host
	import flash_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link
	flash_link_if.host lnk,
	// Command request
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_op,
	input wire logic [31:0] cmd_addr,
	input wire logic cmd_addr4,
	input wire logic cmd_quad,
	input wire logic [3:0] cmd_dummy,
	input wire logic [15:0] cmd_len,
	input wire logic pause_req,
	// Read data
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic busy
);
	host_state_e st_r;
	logic [4:0] div_r;
	logic tick, sck_r, cs_n_r, pause_r, quad_r, drive_r, rv_r;
	logic [39:0] tx_r;
	logic [19:0] rcnt_r, head_r, body_r, total_r;
	logic [7:0] rx_r, rd_r;
	logic [2:0] rbit_r;
	logic a4;
	logic [5:0] aclk;
	logic [31:0] addr_use;
	logic [3:0] io_lvl;

	// Device data pins through the filter
	pin_sync #(.W(4), .RST_VAL(4'hF)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.din(lnk.io),
		.lvl(io_lvl),
		.rise(),
		.fall()
	);

	// Address form and unique-ID zero field
	always_comb
	begin
		a4 = cmd_addr4 | cmd_op == OP_NORMAL_READ_4B |
			cmd_op == OP_FAST_READ_4B; // RULE1 RULE8
		if (cmd_op == OP_UNIQUE_ID_READ || cmd_op == OP_INFO_ROW_READ)
			a4 = 1'b0;
		addr_use = cmd_addr;
		if (cmd_op == OP_UNIQUE_ID_READ)
			addr_use = cmd_addr & ~UID_ZERO_BITS; // RULE15
		if (cmd_quad)
			aclk = a4 ? QPI_ADDR4_CLKS : QPI_ADDR3_CLKS; // RULE12
		else
			aclk = a4 ? SPI_ADDR4_CLKS : SPI_ADDR3_CLKS;
	end

	assign tick = (div_r == SCK_HALF_CYC - 5'h01);

	// Half-period divider for the serial clock
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			div_r <= 5'h00;
		else if (st_r == H_IDLE || tick)
			div_r <= 5'h00;
		else
			div_r <= div_r + 5'h01;

	// Transfer sequencer
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			st_r <= H_IDLE;
			sck_r <= 1'b0;
			cs_n_r <= 1'b1;
			pause_r <= 1'b0;
			quad_r <= 1'b0;
			drive_r <= 1'b0;
			tx_r <= 40'h0000000000;
			rcnt_r <= 20'h00000;
			head_r <= 20'h00000;
			body_r <= 20'h00000;
			total_r <= 20'h00000;
		end
		else
			case (st_r)
				H_IDLE:
					if (cmd_valid)
					begin
						st_r <= H_SETUP;
						cs_n_r <= 1'b0;
						quad_r <= cmd_quad;
						drive_r <= 1'b1;
						rcnt_r <= 20'h00000;
						tx_r <= a4 ? {cmd_op, addr_use} :
							{cmd_op, addr_use[23:0], 8'h00};
						head_r <= 20'(aclk) + 20'(cmd_quad ? QPI_OP_CLKS :
							SPI_OP_CLKS); // RULE9 RULE12
						body_r <= 20'(aclk) + 20'(cmd_quad ? QPI_OP_CLKS :
							SPI_OP_CLKS) + 20'(cmd_dummy); // RULE16
						total_r <= 20'(aclk) + 20'(cmd_quad ? QPI_OP_CLKS :
							SPI_OP_CLKS) + 20'(cmd_dummy) +
							(cmd_quad ? {3'b000, cmd_len, 1'b0} :
							{1'b0, cmd_len, 3'b000});
					end
				H_SETUP:
					if (tick)
						st_r <= H_RUN;
				H_RUN:
					if (tick && !sck_r)
					begin
						if (pause_req || pause_r)
							pause_r <= pause_req; // RULE17
						else if (rcnt_r == total_r)
							st_r <= H_END;
						else
						begin
							sck_r <= 1'b1; // RULE9
							rcnt_r <= rcnt_r + 20'h00001;
						end
					end
					else if (tick)
					begin
						sck_r <= 1'b0;
						tx_r <= quad_r ? {tx_r[35:0], 4'h0} :
							{tx_r[38:0], 1'b0};
						if (rcnt_r >= head_r)
							drive_r <= 1'b0;
					end
				H_END:
					if (tick)
					begin
						cs_n_r <= 1'b1; // RULE6
						st_r <= H_GAP;
					end
				H_GAP:
					if (div_r == DESEL_CYC - 5'h01)
						st_r <= H_IDLE;
				default: st_r <= H_IDLE;
			endcase

	// Read data capture on rising edges
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			rx_r <= 8'h00;
			rd_r <= 8'h00;
			rbit_r <= 3'h0;
			rv_r <= 1'b0;
		end
		else
		begin
			rv_r <= 1'b0;
			if (st_r == H_IDLE)
				rbit_r <= 3'h0;
			else if (st_r == H_RUN && tick && !sck_r && !pause_req &&
				!pause_r && rcnt_r != total_r && rcnt_r >= body_r)
			begin
				rx_r <= quad_r ? {rx_r[3:0], io_lvl} :
					{rx_r[6:0], io_lvl[1]};
				rbit_r <= rbit_r + (quad_r ? 3'h4 : 3'h1);
				if (rbit_r == (quad_r ? 3'h4 : 3'h7))
				begin
					rd_r <= quad_r ? {rx_r[3:0], io_lvl} :
						{rx_r[6:0], io_lvl[1]};
					rv_r <= 1'b1;
				end
			end
		end

	// Pin drive
	assign lnk.sck = sck_r;
	assign lnk.cs_n = cs_n_r;
	assign lnk.hold_n = ~pause_r;
	assign lnk.host_o = quad_r ? tx_r[39:36] : {3'b000, tx_r[39]};
	assign lnk.host_oe_n = !drive_r ? 4'hF : (quad_r ? 4'h0 : 4'hE);
	assign cmd_ready = (st_r == H_IDLE);
	assign busy = (st_r != H_IDLE);
	assign rd_data = rd_r;
	assign rd_valid = rv_r;
endmodule : flash_host
`default_nettype wire

// >>> testbench/flash_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module flash_link_properties
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link wires
	input wire logic sck,
	input wire logic cs_n,
	input wire logic hold_n,
	input wire logic [3:0] dev_o,
	input wire logic [3:0] dev_oe_n,
	input wire logic [3:0] host_o,
	input wire logic [3:0] host_oe_n,
	// Pause function enabled at the device
	input wire logic hold_ok
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Deselect and framing
	a_desel_release: assert property (
		$rose(cs_n) |-> ##[0:8] (&dev_oe_n))
		else $error("output held after deselect");
	a_gap_held: assert property (
		$rose(cs_n) |=> cs_n [*8])
		else $error("deselect gap too short");
	a_sck_framed: assert property (
		cs_n |-> !$rose(sck))
		else $error("clock rise while deselected");
	a_host_setup: assert property (
		$rose(sck) && !host_oe_n[0] |-> $stable(host_o & ~host_oe_n))
		else $error("host data moved at sampling edge");
	a_dev_launch: assert property (
		(dev_oe_n != 4'hF) && $changed(dev_o) |-> !sck)
		else $error("device data moved while clock high");
	a_one_driver: assert property (
		((~dev_oe_n) & (~host_oe_n)) == 4'h0)
		else $error("both ends drive one line");
	// Pause behaviour
	a_hold_edge: assert property (
		$changed(hold_n) |-> !(sck && $past(sck)))
		else $error("pause changed while clock high");
	a_hold_frozen: assert property (
		!hold_n |-> !$rose(sck))
		else $error("clock rise during pause");
	a_hold_quiet: assert property (
		(hold_ok && !hold_n) [*8] |-> (&dev_oe_n))
		else $error("device drives during pause");
	a_hold_ignored: assert property (
		(!hold_ok && !hold_n && !cs_n) [*2] |-> $stable(dev_oe_n))
		else $error("pause taken while disabled");
	// Main scenarios reached
	c_frame: cover property ($fell(cs_n));
	c_pause: cover property ($fell(hold_n));
	c_pause_off: cover property (!hold_ok && $fell(hold_n));
	c_quad_data: cover property (dev_oe_n == 4'h0);
endmodule : flash_link_properties
`default_nettype wire

// >>> testbench/serial_flash_read_front_end_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_read_front_end_tb_top
	import flash_pkg::*;
;
	logic clk, rstn, mem_rd, cmd_ignored, cmd_valid, cmd_ready;
	logic write_in_progress, four_byte_addr_flag, quad_command_mode;
	logic cmd_addr4, cmd_quad, pause_req, rd_valid, busy, sck_d;
	logic read_active;
	logic [2:0] hold_dis;
	logic [3:0] fdum, cmd_dummy;
	logic [24:0] mem_addr;
	logic [1:0] mem_space;
	logic [7:0] mem_rdata, cmd_op, rd_data, opsh, r;
	logic [31:0] cmd_addr;
	logic [15:0] cmd_len;
	logic [7:0] qops [5] = '{OP_FAST_READ, OP_FAST_READ_4B,
		OP_QUAD_IO_FAST_READ, OP_UNIQUE_ID_READ, OP_INFO_ROW_READ};
	logic [7:0] rops [4] = '{OP_NORMAL_READ, OP_NORMAL_READ_4B,
		OP_FAST_READ, OP_FAST_READ_4B};
	int nrise = 0;
	int hold_en = 0;
	int hcnt = 0;
	int ign_cnt = 0;
	int mrd_cnt = 0;
	int act_cnt = 0;
	int mismatches = 0;
	int samples_checked = 0;
	int seed = 32'hBBAA;
	flash_link_if lnk ();
	flash_device #(.BIG_DEVICE(1'b1)) u_flash_device (.clk, .rstn, .lnk,
		.write_in_progress, .four_byte_addr_flag, .quad_command_mode,
		.quad_enable(hold_dis[0]), .dtr_mode(hold_dis[1]),
		.reset_pin_sel(hold_dis[2]),
		.fast_dummy_cfg(fdum), .qpi_dummy_cfg(fdum), .mem_rd, .mem_addr,
		.mem_space, .mem_rdata, .read_active, .cmd_ignored);
	flash_host u_flash_host (.clk, .rstn, .lnk, .cmd_valid, .cmd_ready,
		.cmd_op, .cmd_addr, .cmd_addr4, .cmd_quad, .cmd_dummy, .cmd_len,
		.pause_req, .rd_data, .rd_valid, .busy);
	flash_link_properties u_props (.clk, .rstn, .sck(lnk.sck),
		.cs_n(lnk.cs_n), .hold_n(lnk.hold_n), .dev_o(lnk.dev_o),
		.dev_oe_n(lnk.dev_oe_n), .host_o(lnk.host_o),
		.host_oe_n(lnk.host_oe_n), .hold_ok(hold_dis == 3'b000));
	// Memory contents as a function of address and space
	function automatic logic [7:0] memval(input logic [24:0] a,
		input logic [1:0] s);
		return a[7:0] ^ a[15:8] ^ a[24:17] ^ {6'h00, s};
	endfunction : memval
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Memory, counters, pause window, opcode capture on io0
	always @(posedge clk)
	begin
		if (mem_rd) mem_rdata <= memval(mem_addr, mem_space);
		ign_cnt <= ign_cnt + int'(cmd_ignored);
		mrd_cnt <= mrd_cnt + int'(mem_rd);
		act_cnt <= act_cnt + int'(read_active);
		hcnt <= busy ? hcnt + 1 : 0;
		pause_req <= hold_en != 0 && hcnt > 900 && hcnt < 1400;
		sck_d <= lnk.sck;
		if (lnk.cs_n) nrise <= 0;
		else if (lnk.sck && !sck_d && nrise < 8)
		begin
			opsh <= {opsh[6:0], lnk.io[0]};
			nrise <= nrise + 1;
		end
	end
	task automatic check_byte(input logic [7:0] got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_byte
	task automatic check_count(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_count
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// One read; f holds four-byte flag, quad mode, write in progress
	task automatic run(input logic [7:0] op, input logic [31:0] a,
		input logic [2:0] f, input logic [3:0] d, input logic [15:0] n);
		logic [1:0] sp;
		logic [24:0] msk;
		logic [24:0] ea;
		logic [15:0] got;
		int i0;
		int m0;
		int a0;
		sp = op == OP_UNIQUE_ID_READ ? 2'h1 : {op == OP_INFO_ROW_READ, 1'b0};
		msk = sp == 2'h1 ? MASK_UID : MASK_VMSB23;
		if ((f[2] && sp == 2'h0) || op == OP_NORMAL_READ_4B ||
			op == OP_FAST_READ_4B)
			msk = MASK_VMSB24;
		ea = a[24:0] & msk;
		if (sp == 2'h1) ea = ea & ~UID_ZERO_BITS[24:0];
		got = 16'h0000;
		@(posedge clk);
		write_in_progress <= f[0];
		quad_command_mode <= f[1];
		four_byte_addr_flag <= f[2];
		fdum <= d;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_addr4 <= msk == MASK_VMSB24;
		cmd_quad <= f[1];
		// Normal reads carry no dummy clocks
		cmd_dummy <= (op == OP_NORMAL_READ ||
			op == OP_NORMAL_READ_4B) ? 4'h0 : d;
		cmd_len <= n;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		i0 = ign_cnt;
		m0 = mrd_cnt;
		a0 = act_cnt;
		for (int k = 0; busy || k == 0; k++)
		begin
			@(negedge clk);
			if (k == 0) check_count({15'h0000, cmd_ready}, 16'h0000);
			if (rd_valid)
			begin
				check_byte(rd_data, f[0] ? 8'hFF : memval(ea, sp));
				ea = (ea + 25'h0000001) & msk;
				got++;
			end
			if (k > 30000)
			begin
				mismatches++;
				print_verdict();
			end
		end
		check_count(got, n);
		check_count(16'(ign_cnt - i0), {15'h0000, f[0]});
		if (f[0]) check_count(16'(mrd_cnt - m0), 16'h0000);
		if (!f[1]) check_byte(opsh, op);
		check_count({15'h0000, act_cnt != a0}, {15'h0000, !f[0]});
	endtask : run
	// Main sequence
	initial
	begin
		rstn = 1'b0;
		{cmd_valid, cmd_op, cmd_addr, cmd_addr4, cmd_quad} = '0;
		{cmd_dummy, cmd_len, fdum, hold_dis} = '0;
		{write_in_progress, four_byte_addr_flag, quad_command_mode} = '0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		check_byte({6'h00, lnk.sck, lnk.cs_n}, 8'h01);
		run(OP_NORMAL_READ, 32'hA5123456, 3'b000, 4'h8, 16'h0003);
		run(OP_NORMAL_READ, $random(seed), 3'b100, 4'h8, 16'h0002);
		run(OP_NORMAL_READ_4B, 32'hFFFFFFFE, 3'b000, 4'h8, 16'h0003);
		run(OP_NORMAL_READ, 32'h00FFFFFF, 3'b000, 4'h8, 16'h0002);
		run(OP_FAST_READ_4B, $random(seed), 3'b000, 4'h5, 16'h0002);
		for (int i = 0; i < 3; i++)
			run(rops[2 * (i & 1)], 32'h10, {1'b0, i == 2, 1'b1}, 4'h6, 16'h0002);
		for (int i = 0; i < 5; i++)
		begin
			r = 8'($random(seed));
			run(qops[i], i == 4 ? 32'h40 : $random(seed), {i[0], 2'b10},
				4'h4 + {1'b0, r[2:0]}, 16'h0003);
		end
		hold_en = 1;
		run(OP_FAST_READ, $random(seed), 3'b000, 4'h8, 16'h0004);
		// Pause must be ignored with each disabling condition
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			hold_dis <= 3'b001 << i;
			run(OP_FAST_READ, $random(seed), 3'b000, 4'h8, 16'h0004);
		end
		@(posedge clk);
		hold_dis <= 3'b000;
		hold_en = 0;
		for (int i = 0; i < 6; i++)
		begin
			r = 8'($random(seed));
			run(rops[r[1:0]], $random(seed), {r[2], 2'b00},
				4'h4 + {1'b0, r[5:3]}, {14'h0000, r[7:6]} + 16'h0001);
		end
		print_verdict();
	end
endmodule : serial_flash_read_front_end_tb_top
`default_nettype wire
